// ### logic/rts_defines.vh
// Constants for the ramp time selector: register offsets, field positions,
// reset values, sentinel codes and timing counts.
// Assumes inclusion by bare name from the design file.
`ifndef RTS_DEFINES_VH
`define RTS_DEFINES_VH

// ==================================================================
// Register byte offsets
`define RTS_OFF_CTRL        8'h00
`define RTS_OFF_PRIMARY     8'h04
`define RTS_OFF_SECOND      8'h08
`define RTS_OFF_LOW_SPEED   8'h0C
`define RTS_OFF_EMERGENCY   8'h10
`define RTS_OFF_SWITCH      8'h14
`define RTS_OFF_BRAKE_START 8'h18
`define RTS_OFF_RATE        8'h1C
`define RTS_OFF_TERM_FUNC   8'h20
`define RTS_OFF_SELECTED    8'h24
`define RTS_OFF_STATUS      8'h28

// ==================================================================
// Control register fields
`define RTS_CTRL_UNIT       0
`define RTS_CTRL_PM_MODE    1
`define RTS_CTRL_COMM_ESTOP 2
`define RTS_CTRL_FAULT_CLR  3

// Status register fields
`define RTS_ST_SECOND       0
`define RTS_ST_LOW_SPEED    1
`define RTS_ST_EMERGENCY    2
`define RTS_ST_FAULT        3
`define RTS_ST_UNIT         4

// ==================================================================
// Reset values
`define RTS_RST_CTRL        32'h0000_0000
`define RTS_RST_PRIMARY     32'h0032_0032
`define RTS_RST_SECOND      32'h270F_0032
`define RTS_RST_LOW_SPEED   32'h270F_270F
`define RTS_RST_EMERGENCY   32'h0000_0032
`define RTS_RST_SWITCH      32'h0000_270F
`define RTS_RST_BRAKE_START 32'h0032_012C
`define RTS_RST_RATE        32'h270F_1770
`define RTS_RST_TERM_FUNC   32'h0000_0000

// ==================================================================
// Setting codes
`define RTS_SENTINEL        16'h270F
`define RTS_ESTOP_CODE      8'h5C
`define RTS_LOW_SPEED_MUL   20'h0_000A

// ==================================================================
// Timing: speed change rate is measured over one window.
`define RTS_CLK_PERIOD_NS   8
`define RTS_RATE_WINDOW_NS  1000000
`define RTS_RATE_CYCLES     (`RTS_RATE_WINDOW_NS / `RTS_CLK_PERIOD_NS)

`endif

// ### logic/rts_ramp_time_selector.v
// Ramp time selector: picks the acceleration and deceleration time for the
// frequency ramp generator and watches the motor speed change rate.
// Assumes an AHB-Lite master on hclk, inputs synchronous to hclk, and a ramp
// generator that interprets the chosen times in the reported time unit.
//
// Decided for this implementation: the address map and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "rts_defines.vh"

module rts_ramp_time_selector #(
	parameter integer RATE_CYCLES = `RTS_RATE_CYCLES
) (
	// Clock and reset
	input  wire        hclk,
	input  wire        hresetn,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [7:0]  haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg         hreadyout,
	output reg  [31:0] hrdata,
	output reg         hresp,
	// Drive inputs
	input  wire        second_set_select,
	input  wire [3:0]  terminal_in,
	input  wire [15:0] output_frequency,
	input  wire [15:0] motor_speed_frequency,
	// Ramp generator outputs
	output reg  [15:0] sel_accel_time,
	output reg  [15:0] sel_decel_time,
	output reg         time_unit_fine,
	output reg  [15:0] torque_limit_level,
	output reg         torque_limit_en,
	output reg         emergency_stop_indication,
	output reg         accel_error_fault,
	output reg         output_shutoff
);

	// ==================================================================
	// Helpers
	function [15:0] lo16;
		input [31:0] w;
		lo16 = w[15:0];
	endfunction

	function [15:0] hi16;
		input [31:0] w;
		hi16 = w[31:16];
	endfunction

	function [15:0] max16;
		input [15:0] a;
		input [15:0] b;
		max16 = (a > b) ? a : b;
	endfunction

	// Low-speed time never below the primary time; 9999 means use primary.
	function [15:0] low_eff;
		input [15:0] low;
		input [15:0] prim;
		low_eff = (low == `RTS_SENTINEL || low < prim) ? prim : low;
	endfunction

	// ==================================================================
	// Registers
	reg [31:0] ctrl_r;
	reg [31:0] primary_r;
	reg [31:0] second_r;
	reg [31:0] low_speed_r;
	reg [31:0] emergency_r;
	reg [31:0] switch_r;
	reg [31:0] brake_start_r;
	reg [31:0] rate_r;
	reg [31:0] term_func_r;

	reg        wr_pend_r;
	reg [7:0]  wr_addr_r;
	reg        fault_r;
	reg        fault_nxt;
	reg [15:0] prev_speed_r;
	reg [16:0] tick_cnt_r;
	reg        second_act_r;
	reg        low_act_r;
	reg        estop_act_r;

	wire addr_phase = hsel & hready & htrans[1];
	wire do_write   = wr_pend_r;
	wire clr_fault  = do_write && wr_addr_r == `RTS_OFF_CTRL && hwdata[`RTS_CTRL_FAULT_CLR];

	// ==================================================================
	// Register write path; writes land in the data phase.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r     <= 1'b0;
			wr_addr_r     <= 8'h00;
			ctrl_r        <= `RTS_RST_CTRL;
			primary_r     <= `RTS_RST_PRIMARY;
			second_r      <= `RTS_RST_SECOND;
			low_speed_r   <= `RTS_RST_LOW_SPEED;
			emergency_r   <= `RTS_RST_EMERGENCY;
			switch_r      <= `RTS_RST_SWITCH;
			brake_start_r <= `RTS_RST_BRAKE_START;
			rate_r        <= `RTS_RST_RATE;
			term_func_r   <= `RTS_RST_TERM_FUNC;
		end else begin
			wr_pend_r <= addr_phase & hwrite;
			if (addr_phase) begin
				wr_addr_r <= haddr;
			end
			if (do_write) begin
				case (wr_addr_r)
				`RTS_OFF_CTRL: begin
					ctrl_r <= {29'h0000_0000, hwdata[2:0]};
				end
				`RTS_OFF_PRIMARY: begin
					primary_r <= hwdata;
				end
				`RTS_OFF_SECOND: begin
					second_r <= hwdata;
				end
				`RTS_OFF_LOW_SPEED: begin
					low_speed_r <= hwdata;
				end
				`RTS_OFF_EMERGENCY: begin
					emergency_r <= hwdata;
				end
				`RTS_OFF_SWITCH: begin
					switch_r <= {16'h0000, hwdata[15:0]};
				end
				`RTS_OFF_BRAKE_START: begin
					brake_start_r <= hwdata;
				end
				`RTS_OFF_RATE: begin
					rate_r <= hwdata;
				end
				`RTS_OFF_TERM_FUNC: begin
					term_func_r <= hwdata;
				end
				default: begin
					ctrl_r <= ctrl_r;
				end
				endcase
			end
		end
	end

	// ==================================================================
	// Emergency stop source
	reg term_stop;
	integer i;
	always @* begin
		term_stop = 1'b0;
		for (i = 0; i < 4; i = i + 1) begin
			// A terminal carries the stop only once its function code is assigned.
			if (term_func_r[8*i +: 8] == `RTS_ESTOP_CODE && !terminal_in[i]) begin
				term_stop = 1'b1;
			end
		end
	end
	wire estop = term_stop | ctrl_r[`RTS_CTRL_COMM_ESTOP];

	// ==================================================================
	// Time selection
	wire [15:0] sw_freq   = lo16(switch_r);
	wire [15:0] dc_brake  = lo16(brake_start_r);
	wire [15:0] start_frq = hi16(brake_start_r);
	wire [15:0] rated     = lo16(rate_r);
	wire [15:0] fault_lvl = hi16(rate_r);
	wire        pm_mode   = ctrl_r[`RTS_CTRL_PM_MODE];

	// A threshold at or below brake or start frequency is lifted to them.
	wire [15:0] threshold = max16(sw_freq, max16(dc_brake, start_frq));
	wire        freq_hit  = (sw_freq == 16'h0000) ? 1'b1 :
	                        (sw_freq == `RTS_SENTINEL) ? 1'b0 :
	                        (output_frequency >= threshold);
	wire        use_second = second_set_select | freq_hit;
	wire [19:0] out_x10    = {4'h0, output_frequency} * `RTS_LOW_SPEED_MUL;
	wire        low_range  = out_x10 < {4'h0, rated};
	wire        use_low    = pm_mode & low_range & ~second_set_select;

	wire [15:0] sec_acc = lo16(second_r);
	wire [15:0] sec_dec = (hi16(second_r) == `RTS_SENTINEL) ? sec_acc : hi16(second_r);

	reg [15:0] acc_nxt;
	reg [15:0] dec_nxt;
	always @* begin
		acc_nxt = lo16(primary_r);
		dec_nxt = hi16(primary_r);
		if (estop) begin
			acc_nxt = lo16(emergency_r);
			dec_nxt = lo16(emergency_r);
		end else if (use_second) begin
			acc_nxt = sec_acc;
			dec_nxt = sec_dec;
		end else if (use_low) begin
			acc_nxt = low_eff(lo16(low_speed_r), lo16(primary_r));
			dec_nxt = low_eff(hi16(low_speed_r), hi16(primary_r));
		end
	end

	// ==================================================================
	// Speed change rate monitor
	wire        tick   = (tick_cnt_r == RATE_CYCLES[16:0] - 17'h0_0001);
	wire [15:0] delta  = (motor_speed_frequency >= prev_speed_r) ?
	                     motor_speed_frequency - prev_speed_r :
	                     prev_speed_r - motor_speed_frequency;
	wire        rate_bad = tick & pm_mode & (fault_lvl != `RTS_SENTINEL) &
	                       (delta > fault_lvl);

	always @* begin
		fault_nxt = fault_r;
		if (clr_fault) begin
			fault_nxt = 1'b0;
		end
		// A new violation in the clearing cycle keeps the fault set.
		if (rate_bad) begin
			fault_nxt = 1'b1;
		end
	end

	// ==================================================================
	// Output and state flops, refreshed each cycle except prev_speed_r, which loads on tick.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tick_cnt_r                <= 17'h0_0000;
			prev_speed_r              <= 16'h0000;
			fault_r                   <= 1'b0;
			sel_accel_time            <= 16'h0000;
			sel_decel_time            <= 16'h0000;
			time_unit_fine            <= 1'b0;
			torque_limit_level        <= 16'h0000;
			torque_limit_en           <= 1'b0;
			emergency_stop_indication <= 1'b0;
			accel_error_fault         <= 1'b0;
			output_shutoff            <= 1'b0;
			second_act_r              <= 1'b0;
			low_act_r                 <= 1'b0;
			estop_act_r               <= 1'b0;
		end else begin
			tick_cnt_r <= tick ? 17'h0_0000 : tick_cnt_r + 17'h0_0001;
			if (tick) begin
				prev_speed_r <= motor_speed_frequency;
			end
			fault_r                   <= fault_nxt;
			accel_error_fault         <= fault_nxt;
			output_shutoff            <= fault_nxt;
			sel_accel_time            <= acc_nxt;
			sel_decel_time            <= dec_nxt;
			time_unit_fine            <= ctrl_r[`RTS_CTRL_UNIT];
			torque_limit_level        <= hi16(emergency_r);
			torque_limit_en           <= estop;
			emergency_stop_indication <= estop;
			second_act_r              <= ~estop & use_second;
			low_act_r                 <= ~estop & ~use_second & use_low;
			estop_act_r               <= estop;
		end
	end

	// ==================================================================
	// Read path; data is registered so every access has zero wait states.
	reg [31:0] rd_nxt;
	always @* begin
		rd_nxt = 32'h0000_0000;
		case (haddr)
		`RTS_OFF_CTRL:        rd_nxt = ctrl_r;
		`RTS_OFF_PRIMARY:     rd_nxt = primary_r;
		`RTS_OFF_SECOND:      rd_nxt = second_r;
		`RTS_OFF_LOW_SPEED:   rd_nxt = low_speed_r;
		`RTS_OFF_EMERGENCY:   rd_nxt = emergency_r;
		`RTS_OFF_SWITCH:      rd_nxt = switch_r;
		`RTS_OFF_BRAKE_START: rd_nxt = brake_start_r;
		`RTS_OFF_RATE:        rd_nxt = rate_r;
		`RTS_OFF_TERM_FUNC:   rd_nxt = term_func_r;
		`RTS_OFF_SELECTED:    rd_nxt = {sel_decel_time, sel_accel_time};
		`RTS_OFF_STATUS:      rd_nxt = {27'h000_0000, time_unit_fine, fault_r,
		                                estop_act_r, low_act_r, second_act_r};
		default:              rd_nxt = 32'h0000_0000;
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (addr_phase && !hwrite) begin
				hrdata <= rd_nxt;
			end
		end
	end

endmodule // rts_ramp_time_selector

`default_nettype wire

// ### verification/rts_monitor.sv
// Checker for the ramp time selector, bound to the top module ports.
// Assumes one hclk domain and an asynchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module rts_monitor (
	// Clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// Register bus
	input wire logic        hsel,
	input wire logic [7:0]  haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// Drive inputs
	input wire logic        second_set_select,
	input wire logic [3:0]  terminal_in,
	input wire logic [15:0] output_frequency,
	// Ramp generator side
	input wire logic [15:0] sel_accel_time,
	input wire logic [15:0] sel_decel_time,
	input wire logic        time_unit_fine,
	input wire logic [15:0] torque_limit_level,
	input wire logic        torque_limit_en,
	input wire logic        emergency_stop_indication,
	input wire logic        accel_error_fault,
	input wire logic        output_shutoff
);
	// ====================
	// Write tracking
	logic wr_r;
	logic wc_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_r <= 1'b0;
			wc_r <= 1'b0;
		end else begin
			wr_r <= hsel && hready && htrans[1] && hwrite;
			wc_r <= hsel && hready && htrans[1] && hwrite && haddr == 8'h00;
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Inputs and settings untouched for four cycles.
	sequence quiet_s;
		($stable(second_set_select) && $stable(terminal_in) && $stable(output_frequency)
			&& !wr_r)[*4];
	endsequence
	sequence ctrl_wrote_s;
		$past(wc_r) || $past(wc_r, 2);
	endsequence
	// ====================
	// Properties
	a_times_follow: assert property (quiet_s |=> $stable(sel_accel_time)
		&& $stable(sel_decel_time)) else $error("times moved with quiet inputs");
	a_fault_shutoff: assert property (accel_error_fault == output_shutoff)
		else $error("fault and shutoff differ");
	a_fault_sticky: assert property ($fell(accel_error_fault) |-> ctrl_wrote_s)
		else $error("fault dropped without clear");
	a_estop_flags: assert property (emergency_stop_indication == torque_limit_en)
		else $error("indication and torque limit differ");
	a_estop_times: assert property (emergency_stop_indication |->
		sel_accel_time == sel_decel_time) else $error("emergency times differ");
	a_unit_change: assert property ($changed(time_unit_fine) |-> ctrl_wrote_s)
		else $error("time unit moved without write");
	a_torque_level: assert property ($changed(torque_limit_level) |->
		$past(wr_r) || $past(wr_r, 2)) else $error("torque level moved without write");
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus not ready or not okay");
endmodule // rts_monitor
`default_nettype wire

// ### verification/rts_ramp_model.sv
// Behavioural frequency ramp generator on the far side of the selector.
// Assumes target and step come from the bench; shutoff drops output at once.
`timescale 1ns/100ps
`default_nettype none
module rts_ramp_model (
	// Clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// Control
	input wire logic [15:0] target,
	input wire logic [15:0] step,
	input wire logic        output_shutoff,
	// Output
	output var logic [15:0] output_frequency
);
	// ====================
	// Ramp
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn || output_shutoff)
			output_frequency <= 16'h0000;
		else if (target > output_frequency)
			output_frequency <= (target - output_frequency > step) ? output_frequency + step : target;
		else
			output_frequency <= (output_frequency - target > step) ? output_frequency - step : target;
	end
endmodule // rts_ramp_model
`default_nettype wire

// ### verification/rts_ramp_time_selector_test.sv
// Self-checking bench for the ramp time selector.
// Assumes the design with the defines file it includes, the ramp model and the monitor that it binds; no other files.
`timescale 1ns/100ps
`default_nettype none
module rts_ramp_time_selector_test;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, sel2 = 1'b0;
	logic [7:0]  haddr = 8'h00;
	logic [1:0]  htrans = 2'b00;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [3:0]  terminal_in = 4'hF;
	logic [15:0] target = 16'h0000, step = 16'hFFFF;
	wire         hreadyout, hresp, unit, ten, ind, fault, shutoff;
	wire  [31:0] hrdata;
	wire  [15:0] acc, dec, level, freq;
	int          fail_count = 0, check_count = 0;
	always #4 hclk = ~hclk;
	rts_ramp_time_selector #(.RATE_CYCLES(16)) rts_ramp_time_selector_inst (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .second_set_select(sel2), .terminal_in(terminal_in),
		.output_frequency(freq), .motor_speed_frequency(freq), .sel_accel_time(acc),
		.sel_decel_time(dec), .time_unit_fine(unit), .torque_limit_level(level),
		.torque_limit_en(ten), .emergency_stop_indication(ind), .accel_error_fault(fault),
		.output_shutoff(shutoff));
	rts_ramp_model rts_ramp_model_inst (.hclk(hclk), .hresetn(hresetn), .target(target),
		.step(step), .output_shutoff(shutoff), .output_frequency(freq));
	// ====================
	// Shared tasks
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
		// An idle cycle keeps a following read clear of the old value.
		@(posedge hclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		chk("register", e, q);
	endtask
	task automatic times(input logic [15:0] a, input logic [15:0] d);
		repeat (4) @(posedge hclk);
		chk("times", {d, a}, {dec, acc});
	endtask
	task automatic set_f(input logic [15:0] f);
		target <= f;
		repeat (2) @(posedge hclk);
	endtask
	// ====================
	// Scenarios
	task automatic t_reset();
		rd(8'h04, 32'h0032_0032);
		rd(8'h08, 32'h270F_0032);
		rd(8'h14, 32'h0000_270F);
		rd(8'h30, 32'h0000_0000);
		times(16'h0032, 16'h0032);
	endtask
	task automatic t_second();
		wr(8'h04, 32'h0014_000A);
		wr(8'h08, 32'h0064_0050);
		sel2 <= 1'b1;
		times(16'h0050, 16'h0064);
		rd(8'h24, 32'h0064_0050);
		wr(8'h08, 32'h270F_0050);
		times(16'h0050, 16'h0050);
		sel2 <= 1'b0;
		times(16'h000A, 16'h0014);
	endtask
	task automatic t_switch();
		wr(8'h14, 32'h0000_03E8);
		set_f(16'h03E7);
		times(16'h000A, 16'h0014);
		set_f(16'h03E8);
		times(16'h0050, 16'h0050);
		wr(8'h14, 32'h0000_0064);
		set_f(16'h00C8);
		times(16'h000A, 16'h0014);
		set_f(16'h012C);
		times(16'h0050, 16'h0050);
		wr(8'h14, 32'h0000_0000);
		set_f(16'h0000);
		times(16'h0050, 16'h0050);
		wr(8'h14, 32'h0000_270F);
		set_f(16'h03E8);
		times(16'h000A, 16'h0014);
	endtask
	task automatic t_low();
		wr(8'h00, 32'h0000_0003);
		set_f(16'h0257);
		times(16'h000A, 16'h0014);
		chk("unit", 32'h0000_0001, {31'h0000_0000, unit});
		wr(8'h0C, 32'h0005_0100);
		times(16'h0100, 16'h0014);
		set_f(16'h0258);
		times(16'h000A, 16'h0014);
		set_f(16'h0257);
		sel2 <= 1'b1;
		times(16'h0050, 16'h0050);
		rd(8'h28, 32'h0000_0011);
		sel2 <= 1'b0;
		wr(8'h00, 32'h0000_0000);
	endtask
	task automatic t_estop();
		wr(8'h10, 32'h0077_0033);
		wr(8'h20, 32'h0000_005C);
		sel2 <= 1'b1;
		times(16'h0050, 16'h0050);
		terminal_in <= 4'hE;
		times(16'h0033, 16'h0033);
		chk("flags", 32'h0003_0077, {14'h0000, ind, ten, level});
		terminal_in <= 4'hF;
		wr(8'h00, 32'h0000_0004);
		times(16'h0033, 16'h0033);
		rd(8'h28, 32'h0000_0004);
		wr(8'h00, 32'h0000_0000);
		sel2 <= 1'b0;
		times(16'h000A, 16'h0014);
	endtask
	task automatic t_fault();
		wr(8'h00, 32'h0000_0002);
		set_f(16'h0BB8);
		repeat (48) @(posedge hclk);
		chk("fault", 32'h0000_0000, {30'h0000_0000, fault, shutoff});
		wr(8'h1C, 32'h0064_1770);
		repeat (48) @(posedge hclk);
		chk("fault", 32'h0000_0000, {30'h0000_0000, fault, shutoff});
		set_f(16'h1388);
		repeat (40) @(posedge hclk);
		chk("fault", 32'h0000_0003, {30'h0000_0000, fault, shutoff});
		target <= 16'h0000;
		repeat (40) @(posedge hclk);
		wr(8'h00, 32'h0000_000A);
		repeat (40) @(posedge hclk);
		chk("fault", 32'h0000_0000, {30'h0000_0000, fault, shutoff});
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#(8 * 20000);
		fail_count++;
		report_and_stop();
	end
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_second();
		t_switch();
		t_low();
		t_estop();
		t_fault();
		report_and_stop();
	end
endmodule // rts_ramp_time_selector_test
bind rts_ramp_time_selector rts_monitor rts_monitor_inst (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .second_set_select(second_set_select),
	.terminal_in(terminal_in), .output_frequency(output_frequency),
	.sel_accel_time(sel_accel_time), .sel_decel_time(sel_decel_time),
	.time_unit_fine(time_unit_fine), .torque_limit_level(torque_limit_level),
	.torque_limit_en(torque_limit_en), .emergency_stop_indication(emergency_stop_indication),
	.accel_error_fault(accel_error_fault), .output_shutoff(output_shutoff));
`default_nettype wire
